/* File: src/usb_in_ep_pkg.sv */
package usb_in_ep_pkg;

    // ************************************************************
    // Sizes and reset values
    // ************************************************************
    localparam int PKT_DEPTH = 64;
    localparam int PTR_W = 7;
    localparam logic [PTR_W-1:0] PTR_ZERO = 7'h00;
    localparam logic [PTR_W-1:0] PTR_ONE = 7'h01;
    localparam logic [PTR_W-1:0] PTR_FULL = 7'h40;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        XFER_CONTROL,
        XFER_ISOCHRONOUS,
        XFER_BULK,
        XFER_INTERRUPT
    } xfer_kind_type;

    // Requests from software toward the endpoint.
    typedef struct packed {
        logic wr_valid;
        logic [7:0] wr_data;
        logic set_loaded;
        logic clr_acked;
    } sw_req_type;

    // Status shown to software.
    typedef struct packed {
        logic loaded;
        logic acked;
        logic irq;
        logic [PTR_W-1:0] level;
    } sw_stat_type;

    // Events and flow control from the USB link engine.
    typedef struct packed {
        logic in_token;
        logic host_ack;
        logic tx_ready;
    } host_req_type;

    // Data packet stream toward the USB link engine.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
        logic empty;
        logic nak;
    } host_tx_type;

endpackage

/* File: src/usb_in_pkt_store.sv */
module usb_in_pkt_store
    import usb_in_ep_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic release_all,
    input wire logic [PTR_W-1:0] rd_ptr,
    output logic [7:0] rd_data,
    output logic [PTR_W-1:0] count
);
    logic [7:0] mem [PKT_DEPTH];
    logic [PTR_W-1:0] count_reg;
    logic [PTR_W-1:0] count_next;
    logic do_write;

    // ************************************************************
    // Byte storage
    // ************************************************************
    // Writes beyond the packet size are dropped rather than wrapped,
    // so an overlong load never corrupts bytes already stored.
    assign do_write = wr_en && (count_reg < PTR_FULL);
    assign count_next = release_all ? PTR_ZERO : (do_write ? count_reg + PTR_ONE : count_reg);
    assign rd_data = mem[rd_ptr[PTR_W-2:0]];
    assign count = count_reg;

    // Memory has no reset; only the fill count gives it meaning.
    always_ff @(posedge clk) begin
        if (do_write && !release_all) begin
            mem[count_reg[PTR_W-2:0]] <= wr_data;
        end
    end

    // Fill count of the packet held.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= PTR_ZERO;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

/* File: src/usb_in_endpoint.sv */
// How it works
// - IN data served for control, isochronous, bulk and interrupt transfer kinds.
// - Host ACK after the data packet sets the acknowledged flag.
// - Acknowledged flag set means the buffer is released for the next packet.
// - Interrupt stays asserted as long as the acknowledged flag is set.
module usb_in_endpoint
    import usb_in_ep_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire usb_in_ep_pkg::xfer_kind_type XFER_KIND,
    input wire usb_in_ep_pkg::sw_req_type SW_REQ,
    output usb_in_ep_pkg::sw_stat_type SW_STAT,
    input wire usb_in_ep_pkg::host_req_type HOST_REQ,
    output usb_in_ep_pkg::host_tx_type HOST_TX
);
    import usb_in_ep_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEND,
        ST_WAIT_ACK
    } ep_state_type;

    ep_state_type state_reg;
    ep_state_type state_next;
    logic tx_packet_loaded_flag_reg;
    logic tx_packet_loaded_flag_next;
    logic tx_acknowledged_flag_reg;
    logic tx_acknowledged_flag_next;
    logic irq_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_next;
    logic all_loaded_reg;
    logic all_loaded_next;
    logic tx_valid_reg;
    logic [7:0] tx_data_reg;
    logic tx_last_reg;
    logic tx_empty_reg;
    logic nak_reg;
    logic [7:0] store_rd_data;
    logic [PTR_W-1:0] store_count;

    logic take_packet;
    logic beat_taken;
    logic load_beat;
    logic send_done;
    logic ack_event;
    logic iso_kind;
    logic buffer_free;
    logic store_wr;
    logic release_buffer;
    logic is_last_byte;
    logic nak_due;

    // ************************************************************
    // Packet buffer
    // ************************************************************
    // Software may fill only while no packet is loaded or in flight.
    assign buffer_free = !tx_packet_loaded_flag_reg && (state_reg == ST_IDLE);
    assign store_wr = SW_REQ.wr_valid && buffer_free;
    assign release_buffer = ack_event;

    usb_in_pkt_store u_store (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .wr_en(store_wr),
        .wr_data(SW_REQ.wr_data),
        .release_all(release_buffer),
        .rd_ptr(rd_ptr_reg),
        .rd_data(store_rd_data),
        .count(store_count)
    );

    // ************************************************************
    // Transaction decode
    // ************************************************************
    // Isochronous traffic has no handshake, so it completes at packet end.
    assign iso_kind = (XFER_KIND == XFER_ISOCHRONOUS);
    assign take_packet = (state_reg == ST_IDLE) && HOST_REQ.in_token && tx_packet_loaded_flag_reg;
    assign beat_taken = tx_valid_reg && HOST_REQ.tx_ready;
    assign load_beat = (state_reg == ST_SEND) && !all_loaded_reg && (!tx_valid_reg || HOST_REQ.tx_ready);
    assign send_done = (state_reg == ST_SEND) && all_loaded_reg && beat_taken;
    assign ack_event = ((state_reg == ST_WAIT_ACK) && HOST_REQ.host_ack) || (send_done && iso_kind);
    assign is_last_byte = (store_count == PTR_ZERO) || (rd_ptr_reg + PTR_ONE >= store_count);
    assign rd_ptr_next = take_packet ? PTR_ZERO : (load_beat ? rd_ptr_reg + PTR_ONE : rd_ptr_reg);
    assign all_loaded_next = take_packet ? 1'b0 : (load_beat ? is_last_byte : all_loaded_reg);
    assign nak_due = (state_reg == ST_IDLE) && HOST_REQ.in_token && !tx_packet_loaded_flag_reg;

    // ************************************************************
    // Flags
    // ************************************************************
    // Hardware clear on take; a software set in the same cycle wins and keeps the flag up.
    assign tx_packet_loaded_flag_next = SW_REQ.set_loaded || (tx_packet_loaded_flag_reg && !take_packet);
    // A new acknowledge in the clearing cycle wins over the software clear.
    assign tx_acknowledged_flag_next = ack_event || (tx_acknowledged_flag_reg && !SW_REQ.clr_acked);

    // ************************************************************
    // State machine
    // ************************************************************
    // A repeated IN token while waiting for ACK means the host lost the
    // packet; it is resent from the buffer, which is why release waits for ACK.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take_packet) begin
                    state_next = ST_SEND;
                end
            end
            ST_SEND: begin
                if (send_done) begin
                    state_next = iso_kind ? ST_IDLE : ST_WAIT_ACK;
                end
            end
            ST_WAIT_ACK: begin
                if (HOST_REQ.host_ack) begin
                    state_next = ST_IDLE;
                end else if (HOST_REQ.in_token) begin
                    state_next = ST_SEND;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Control registers.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state_reg <= ST_IDLE;
            tx_packet_loaded_flag_reg <= 1'b0;
            tx_acknowledged_flag_reg <= 1'b0;
            irq_reg <= 1'b0;
            rd_ptr_reg <= PTR_ZERO;
            all_loaded_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            tx_packet_loaded_flag_reg <= tx_packet_loaded_flag_next;
            tx_acknowledged_flag_reg <= tx_acknowledged_flag_next;
            irq_reg <= tx_acknowledged_flag_next;
            rd_ptr_reg <= (state_reg == ST_WAIT_ACK && HOST_REQ.in_token) ? PTR_ZERO : rd_ptr_next;
            all_loaded_reg <= (state_reg == ST_WAIT_ACK && HOST_REQ.in_token) ? 1'b0 : all_loaded_next;
        end
    end

    // ************************************************************
    // Data stream toward the link
    // ************************************************************
    // A zero-length packet goes out as one beat marked empty and last.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            tx_valid_reg <= 1'b0;
            tx_data_reg <= BYTE_ZERO;
            tx_last_reg <= 1'b0;
            tx_empty_reg <= 1'b0;
        end else if (load_beat) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg <= (store_count == PTR_ZERO) ? BYTE_ZERO : store_rd_data;
            tx_last_reg <= is_last_byte;
            tx_empty_reg <= (store_count == PTR_ZERO);
        end else if (beat_taken) begin
            tx_valid_reg <= 1'b0;
            tx_last_reg <= 1'b0;
            tx_empty_reg <= 1'b0;
        end
    end

    // NAK when the host asks and nothing is loaded, for one cycle.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            nak_reg <= 1'b0;
        end else begin
            nak_reg <= nak_due;
        end
    end

    // ************************************************************
    // Output bundles
    // ************************************************************
    assign SW_STAT = '{loaded: tx_packet_loaded_flag_reg, acked: tx_acknowledged_flag_reg,
                       irq: irq_reg, level: store_count};
    assign HOST_TX = '{valid: tx_valid_reg, data: tx_data_reg, last: tx_last_reg,
                       empty: tx_empty_reg, nak: nak_reg};

    // ************************************************************
    // Checks
    // ************************************************************
    sequence ack_in_wait;
        (state_reg == ST_WAIT_ACK) && HOST_REQ.host_ack;
    endsequence

    sequence flag_and_irq_up;
        tx_acknowledged_flag_reg && irq_reg;
    endsequence

    chk_ack_sets_flag: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        ack_in_wait |=> flag_and_irq_up)
        else $error("acknowledged flag not set after host ACK");

    chk_buffer_release: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        $rose(tx_acknowledged_flag_reg) |-> (store_count == PTR_ZERO) && (state_reg == ST_IDLE))
        else $error("buffer not released with acknowledged flag");

    chk_irq_tracks: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        tx_acknowledged_flag_reg && !SW_REQ.clr_acked |=> irq_reg && tx_acknowledged_flag_reg)
        else $error("interrupt dropped while acknowledged flag set");

    chk_take_clears: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        take_packet && !SW_REQ.set_loaded |=> !tx_packet_loaded_flag_reg && (state_reg == ST_SEND))
        else $error("loaded flag not cleared on packet take");

    chk_iso_complete: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        send_done && iso_kind |=> tx_acknowledged_flag_reg && (state_reg == ST_IDLE))
        else $error("isochronous packet did not complete at end");

    // Tokens may come back to back, so the pulse is checked from both ends.
    chk_nak_pulse: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        nak_due |=> HOST_TX.nak)
        else $error("missing NAK after token with nothing loaded");

    chk_nak_cause: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        HOST_TX.nak |-> $past(nak_due))
        else $error("NAK without an unanswered token");
endmodule

/* File: verif/usb_host_model.sv */
module usb_host_model
    import usb_in_ep_pkg::*;
(
    input wire logic clk,
    input wire logic stall,
    input wire logic send_token,
    input wire logic send_ack,
    input wire usb_in_ep_pkg::host_tx_type host_tx,
    output usb_in_ep_pkg::host_req_type host_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Host side of the link
    // ************************************************************
    logic ready_reg = 1'b1;
    logic [7:0] rx_q[$];
    int pkt_count = 0;

    // Tokens and handshakes follow the bench strobes, which change only at falling edges.
    assign host_req = '{in_token: send_token, host_ack: send_ack, tx_ready: ready_reg};

    // A stalling host withholds ready at random, so beats must stand until taken.
    always @(negedge clk) begin
        ready_reg <= stall ? 1'($urandom_range(0, 1)) : 1'b1;
    end

    // A beat counts only at an edge where ready is high; empty beats carry no byte.
    always @(posedge clk) begin
        if (host_tx.valid && ready_reg) begin
            if (!host_tx.empty) begin
                rx_q.push_back(host_tx.data);
            end
            if (host_tx.last) begin
                pkt_count++;
            end
        end
    end
endmodule

/* File: verif/usb_in_endpoint_test.sv */
module usb_in_endpoint_test;
    import usb_in_ep_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Bench
    // ************************************************************
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    xfer_kind_type xfer_kind = XFER_CONTROL;
    sw_req_type sw_req = '0;
    sw_stat_type sw_stat;
    host_req_type host_req;
    host_tx_type host_tx;
    logic stall = 1'b0;
    logic send_token = 1'b0;
    logic send_ack = 1'b0;
    int fail_count = 0;
    int total_checks = 0;
    logic [7:0] exp_q[$];
    int seen_pkts;
    int len;

    usb_in_endpoint dut (.REF_CLK(ref_clk), .RST_N(rst_n), .XFER_KIND(xfer_kind),
        .SW_REQ(sw_req), .SW_STAT(sw_stat), .HOST_REQ(host_req), .HOST_TX(host_tx));
    usb_host_model host (.clk(ref_clk), .stall(stall), .send_token(send_token),
        .send_ack(send_ack), .host_tx(host_tx), .host_req(host_req));

    // Free-running 25 MHz clock.
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic step();
        @(negedge ref_clk);
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (fail_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Writes past the buffer depth are sent too; only the first 64 bytes are expected.
    task automatic load(input int n);
        check("loaded before fill", sw_stat.loaded, 0);
        for (int i = 0; i < n; i++) begin
            sw_req.wr_valid = 1'b1;
            sw_req.wr_data = 8'($urandom);
            if (i < PKT_DEPTH) exp_q.push_back(sw_req.wr_data);
            step();
        end
        sw_req.wr_valid = 1'b0;
        check("level", sw_stat.level, exp_q.size());
        sw_req.set_loaded = 1'b1;
        step();
        sw_req.set_loaded = 1'b0;
        sw_req.wr_valid = 1'b1;
        check("loaded", sw_stat.loaded, 1);
        step();
        sw_req.wr_valid = 1'b0;
        check("level after refused write", sw_stat.level, exp_q.size());
    endtask

    task automatic clear();
        sw_req.clr_acked = 1'b1;
        step();
        sw_req.clr_acked = 1'b0;
        check("acked cleared", sw_stat.acked, 0);
        check("irq cleared", sw_stat.irq, 0);
    endtask

    // The host fetches the packet; with retry it asks again before acknowledging,
    // as after a lost handshake. Only non-isochronous kinds need the handshake.
    task automatic send(input bit retry);
        seen_pkts = host.pkt_count;
        for (int r = 0; r <= int'(retry); r++) begin
            send_token = 1'b1;
            step();
            send_token = 1'b0;
            check("loaded taken", sw_stat.loaded, 0);
            for (int k = 0; k < 300 && host.pkt_count == seen_pkts + r; k++) step();
            check("packets", host.pkt_count, seen_pkts + r + 1);
        end
        check("byte count", host.rx_q.size(), exp_q.size() * (int'(retry) + 1));
        for (int i = 0; i < host.rx_q.size() && exp_q.size() > 0; i++) begin
            check("byte", host.rx_q[i], exp_q[i % exp_q.size()]);
        end
        host.rx_q.delete();
        exp_q.delete();
        if (xfer_kind != XFER_ISOCHRONOUS) begin
            step();
            check("acked before handshake", sw_stat.acked, 0);
            send_ack = 1'b1;
            step();
            send_ack = 1'b0;
        end
        check("acked", sw_stat.acked, 1);
        check("irq", sw_stat.irq, 1);
        check("level released", sw_stat.level, 0);
    endtask

    // Hang guard, far beyond the longest expected run.
    initial begin
        repeat (40000) @(posedge ref_clk);
        fail_count++;
        complete_run();
    end

    // Reset, a token with nothing loaded, then packets of every kind.
    initial begin
        void'($urandom(32'h1c6c));
        repeat (10) step();
        rst_n = 1'b1;
        check("status after reset", sw_stat, '0);
        send_token = 1'b1;
        step();
        send_token = 1'b0;
        send_ack = 1'b1;
        check("nak", host_tx.nak, 1);
        step();
        send_ack = 1'b0;
        check("nak pulse", host_tx.nak, 0);
        check("stray ack", sw_stat.acked, 0);
        for (int p = 0; p < 12; p++) begin
            // Kinds rotate through all four, so isochronous packets exercise the handshake-free completion path.
            xfer_kind = xfer_kind_type'(p % 4);
            stall = 1'($urandom_range(0, 1));
            len = (p == 5) ? 0 : (p == 6) ? 65 : $urandom_range(1, 8);
            load(len);
            if (sw_stat.acked === 1'b1) clear();
            send(xfer_kind != XFER_ISOCHRONOUS && p % 3 == 0);
        end
        clear();
        complete_run();
    end
endmodule
